// ===== inc/scc_defines.vh
`ifndef SCC_DEFINES_VH
`define SCC_DEFINES_VH
// Register addresses on the serial configuration port
`define SCC_ADDR_W 15
`define SCC_ADDR_PRIMARY 15'h0029
`define SCC_ADDR_SECONDARY 15'h002a
`define SCC_ADDR_POS0 15'h002c
`define SCC_ADDR_POS1 15'h002d
`define SCC_ADDR_POS2 15'h002e
// Reset values
`define SCC_PRIMARY_RST 8'h00
`define SCC_SECONDARY_RST 8'h00
// Primary register fields
`define SCC_PROC_EN_BIT 6
`define SCC_RECV_EN_BIT 5
`define SCC_FINE_BIT 4
`define SCC_SEL_MSB 3
`define SCC_SEL_LSB 0
// Secondary register fields
`define SCC_TS_EN_BIT 3
`define SCC_DEVCLK_PECL_BIT 2
`define SCC_SYSREF_PECL_BIT 1
`define SCC_INVERT_BIT 0
// Serial frame: read flag, address, then data bytes
`define SCC_HDR_BITS 5'd16
`define SCC_LAST_BIT 5'd23
// Capture delay line length in clock cycles
`define SCC_DLY_LEN 32
`endif

// ===== design/scc_sync3.v
`timescale 1ns/100ps
module scc_sync3 #(
   parameter W = 1
) (
   // Clock and reset
   input wire clk,
   input wire rst_n,
   // Asynchronous inputs and filtered result
   input wire [W-1:0] async_in,
   output reg [W-1:0] level_q
);
   reg [W-1:0] s1_q;
   reg [W-1:0] s2_q;
   reg [W-1:0] s3_q;
   genvar i;
   generate
      for (i = 0; i < W; i = i + 1) begin : g_bit
         always @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               s1_q[i] <= 1'b0;
               s2_q[i] <= 1'b0;
               s3_q[i] <= 1'b0;
               level_q[i] <= 1'b0;
            end else begin
               s1_q[i] <= async_in[i];
               s2_q[i] <= s1_q[i];
               s3_q[i] <= s2_q[i];
               // A change counts only once two later stages agree
               if (s2_q[i] == s3_q[i]) begin
                  level_q[i] <= s3_q[i];
               end
            end
         end
      end
   endgenerate
endmodule

// ===== design/scc_regs.v
`timescale 1ns/100ps
`include "scc_defines.vh"
// Behaviour
// - Both control registers reset to zero
// - Processor enable gates SYSREF event processing
// - Receiver enable switches SYSREF receiver on
// - Fine scale selects smaller capture delay steps
// - Four-bit field selects SYSREF capture delay
// - Timestamp mode puts SYSREF on sample LSB with output timestamps enabled
// - Timestamp insertion only without decimation
// - Polarity bit inverts SYSREF before alignment
// - Device clock input PECL mode bit
// - SYSREF input PECL mode bit
// - Read-only 24-bit SYSREF edge position status
module scc_regs (
   // Clock and reset
   input wire clk,
   input wire rst_n,
   // Serial configuration port pins
   input wire spi_cs_n,
   input wire spi_sclk,
   input wire spi_sdi,
   output reg spi_sdo_q,
   output reg spi_sdo_oe_q,
   // SYSREF pin and position detector
   input wire sysref_in,
   input wire [23:0] edge_position_in,
   // Sample path
   input wire [11:0] sample_in,
   input wire sample_valid_in,
   input wire output_timestamp_enable,
   input wire decimation_bypass,
   output reg [11:0] sample_q,
   output reg sample_valid_q,
   // Analog and alignment controls
   output reg sysref_receiver_enable_q,
   output reg sysref_processor_enable_q,
   output reg window_delay_fine_scale_q,
   output reg [3:0] capture_delay_select_q,
   output reg sysref_as_timestamp_enable_q,
   output reg device_clock_dc_pecl_mode_q,
   output reg sysref_dc_pecl_mode_q,
   output reg sysref_polarity_invert_q,
   output reg sysref_event_q
);
   wire cs_n_s;
   wire cs_s;
   wire sclk_s;
   wire sdi_s;
   wire sysref_s;
   reg sclk_d1_q;
   reg [4:0] bit_cnt_q;
   reg [7:0] rx_q;
   reg [7:0] tx_q;
   reg rd_q;
   reg [`SCC_ADDR_W-1:0] addr_q;
   reg [23:0] pos_q;
   reg [`SCC_DLY_LEN-1:0] dly_q;
   reg aligned_d1_q;
   wire sclk_rise;
   wire sclk_fall;
   wire [7:0] rx_byte;
   wire [4:0] tap;
   wire aligned;

   // Pin inputs pass four flops before use
   // Select is filtered inverted so the reset level reads as deselected
   scc_sync3 #(.W(4)) u_sync (
      .clk(clk),
      .rst_n(rst_n),
      .async_in({~spi_cs_n, spi_sclk, spi_sdi, sysref_in}),
      .level_q({cs_s, sclk_s, sdi_s, sysref_s})
   );
   assign cs_n_s = !cs_s;

   function [7:0] read_byte;
      input [`SCC_ADDR_W-1:0] a;
      begin
         case (a)
            `SCC_ADDR_PRIMARY: read_byte = {1'b0, sysref_processor_enable_q,
               sysref_receiver_enable_q, window_delay_fine_scale_q,
               capture_delay_select_q};
            `SCC_ADDR_SECONDARY: read_byte = {4'h0, sysref_as_timestamp_enable_q,
               device_clock_dc_pecl_mode_q, sysref_dc_pecl_mode_q,
               sysref_polarity_invert_q};
            `SCC_ADDR_POS0: read_byte = pos_q[7:0];
            `SCC_ADDR_POS1: read_byte = pos_q[15:8];
            `SCC_ADDR_POS2: read_byte = pos_q[23:16];
            default: read_byte = 8'h00;
         endcase
      end
   endfunction

   assign sclk_rise = !cs_n_s && sclk_s && !sclk_d1_q;
   assign sclk_fall = !cs_n_s && !sclk_s && sclk_d1_q;
   assign rx_byte = {rx_q[6:0], sdi_s};

   // Serial frame: read flag, 15-bit address, then bytes with ascending address
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sclk_d1_q <= 1'b0;
         bit_cnt_q <= 5'd0;
         rx_q <= 8'h00;
         tx_q <= 8'h00;
         rd_q <= 1'b0;
         addr_q <= {`SCC_ADDR_W{1'b0}};
         spi_sdo_q <= 1'b0;
         spi_sdo_oe_q <= 1'b0;
      end else begin
         sclk_d1_q <= sclk_s;
         if (cs_n_s) begin
            // Deselect aborts any partial byte
            bit_cnt_q <= 5'd0;
            rd_q <= 1'b0;
            spi_sdo_oe_q <= 1'b0;
            spi_sdo_q <= 1'b0;
         end else begin
            if (sclk_rise) begin
               rx_q <= rx_byte;
               bit_cnt_q <= (bit_cnt_q == `SCC_LAST_BIT) ? `SCC_HDR_BITS :
                  bit_cnt_q + 5'd1;
               if (bit_cnt_q == 5'd0) begin
                  rd_q <= sdi_s;
               end else if (bit_cnt_q < `SCC_HDR_BITS) begin
                  addr_q <= {addr_q[`SCC_ADDR_W-2:0], sdi_s};
               end
               if (bit_cnt_q == `SCC_HDR_BITS - 5'd1) begin
                  tx_q <= read_byte({addr_q[`SCC_ADDR_W-2:0], sdi_s});
               end else if (bit_cnt_q == `SCC_LAST_BIT) begin
                  addr_q <= addr_q + {{(`SCC_ADDR_W-1){1'b0}}, 1'b1};
                  tx_q <= read_byte(addr_q + {{(`SCC_ADDR_W-1){1'b0}}, 1'b1});
               end
            end
            if (sclk_fall && rd_q && bit_cnt_q >= `SCC_HDR_BITS) begin
               spi_sdo_q <= tx_q[7];
               tx_q <= {tx_q[6:0], 1'b0};
               spi_sdo_oe_q <= 1'b1;
            end
         end
      end
   end

   // Control registers; status addresses ignore writes
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         {sysref_processor_enable_q, sysref_receiver_enable_q} <= 2'b00;
         window_delay_fine_scale_q <= 1'b0;
         capture_delay_select_q <= 4'h0;
         sysref_as_timestamp_enable_q <= 1'b0;
         device_clock_dc_pecl_mode_q <= 1'b0;
         sysref_dc_pecl_mode_q <= 1'b0;
         sysref_polarity_invert_q <= 1'b0;
      end else if (sclk_rise && !rd_q && bit_cnt_q == `SCC_LAST_BIT) begin
         if (addr_q == `SCC_ADDR_PRIMARY) begin
            sysref_processor_enable_q <= rx_byte[`SCC_PROC_EN_BIT];
            sysref_receiver_enable_q <= rx_byte[`SCC_RECV_EN_BIT];
            window_delay_fine_scale_q <= rx_byte[`SCC_FINE_BIT];
            capture_delay_select_q <= rx_byte[`SCC_SEL_MSB:`SCC_SEL_LSB];
         end
         if (addr_q == `SCC_ADDR_SECONDARY) begin
            sysref_as_timestamp_enable_q <= rx_byte[`SCC_TS_EN_BIT];
            device_clock_dc_pecl_mode_q <= rx_byte[`SCC_DEVCLK_PECL_BIT];
            sysref_dc_pecl_mode_q <= rx_byte[`SCC_SYSREF_PECL_BIT];
            sysref_polarity_invert_q <= rx_byte[`SCC_INVERT_BIT];
         end
      end
   end

   // Coarse steps are two cycles, fine steps one; fine halves the reach
   assign tap = window_delay_fine_scale_q ? {1'b0, capture_delay_select_q} :
      {capture_delay_select_q, 1'b0};
   assign aligned = dly_q[tap];

   // SYSREF path: invert, gate by receiver, delay, then process
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         dly_q <= {`SCC_DLY_LEN{1'b0}};
         aligned_d1_q <= 1'b0;
         sysref_event_q <= 1'b0;
         pos_q <= 24'h000000;
         sample_q <= 12'h000;
         sample_valid_q <= 1'b0;
      end else begin
         // Receiver off holds the line low so no false edge reaches alignment
         dly_q <= {dly_q[`SCC_DLY_LEN-2:0],
            sysref_receiver_enable_q & (sysref_s ^ sysref_polarity_invert_q)};
         aligned_d1_q <= aligned;
         // Processing assumes the receiver was enabled first
         sysref_event_q <= sysref_processor_enable_q & aligned & !aligned_d1_q;
         pos_q <= edge_position_in;
         sample_valid_q <= sample_valid_in;
         sample_q[11:1] <= sample_in[11:1];
         sample_q[0] <= (sysref_as_timestamp_enable_q && output_timestamp_enable &&
            decimation_bypass) ? aligned : sample_in[0];
      end
   end
endmodule

// ===== verification/scc_regs_checker.sv
`timescale 1ns/100ps
module scc_regs_checker (
   // Clock and reset
   input wire clk,
   input wire rst_n,
   // Port and sample path
   input wire spi_cs_n,
   input wire spi_sdo_oe_q,
   input wire [11:0] sample_in,
   input wire [11:0] sample_q,
   input wire output_timestamp_enable,
   input wire decimation_bypass,
   // Fields and event
   input wire sysref_processor_enable_q,
   input wire sysref_as_timestamp_enable_q,
   input wire sysref_event_q
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   wire ts = sysref_as_timestamp_enable_q & output_timestamp_enable & decimation_bypass;
   wire en = sysref_processor_enable_q | sysref_as_timestamp_enable_q;
   a_reset_zero: assert property ($rose(rst_n) |-> !en) else $error("field set");
   a_sdo_idle: assert property (spi_cs_n [*6] |-> !spi_sdo_oe_q) else $error("sdo on");
   a_proc_hold: assert property (spi_cs_n [*6] |=> $stable(sysref_processor_enable_q))
      else $error("proc moved");
   a_stamp_hold: assert property (spi_cs_n [*6] |=> $stable(sysref_as_timestamp_enable_q))
      else $error("stamp moved");
   a_sample_upper: assert property (sample_q[11:1] == $past(sample_in[11:1]))
      else $error("sample wrong");
   a_lsb_plain: assert property (!$past(ts) |-> sample_q[0] == $past(sample_in[0]))
      else $error("lsb replaced");
   a_event_pulse: assert property (sysref_event_q |=> !sysref_event_q) else $error("long");
   a_event_gated: assert property (sysref_event_q |-> $past(sysref_processor_enable_q))
      else $error("event gated");
endmodule
bind scc_regs scc_regs_checker chk (.*);

// ===== verification/scc_sysref_gen.sv
`timescale 1ns/100ps
module scc_sysref_gen (
   // Clock and request
   input wire clk,
   input wire fire,
   // SYSREF pin, low outside pulses
   output reg sysref
);
   initial sysref = 1'b0;
   always @(posedge clk) sysref <= fire;
endmodule

// ===== verification/scc_regs_tb.sv
`timescale 1ns/100ps
module scc_regs_tb;
   reg clk, rst_n, spi_cs_n, spi_sclk, spi_sdi, fire, sample_valid_in, decimation_bypass;
   reg output_timestamp_enable;
   reg [11:0] sample_in;
   reg [23:0] edge_position_in;
   wire sysref_in, spi_sdo_q, spi_sdo_oe_q, sample_valid_q, sysref_event_q;
   wire sysref_receiver_enable_q, sysref_processor_enable_q, window_delay_fine_scale_q;
   wire sysref_as_timestamp_enable_q, device_clock_dc_pecl_mode_q, sysref_dc_pecl_mode_q;
   wire sysref_polarity_invert_q;
   wire [3:0] capture_delay_select_q;
   wire [11:0] sample_q;
   integer errors, checks;
   reg [7:0] evn = 8'h00;
   scc_regs DUT (.*);
   scc_sysref_gen gen (.clk, .fire, .sysref(sysref_in));
   always @(posedge clk) if (sysref_event_q === 1'b1) evn <= evn + 8'h01;
   task cyc(input integer n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task chk(input [23:0] s, input [23:0] e);
      checks = checks + 1;
      if (s !== e) begin
         errors = errors + 1;
         $display("[ERR] %0t saw %h want %h", $time, s, e);
      end
   endtask
   task test_done;
      $display("errors=%0d checks=%0d", errors, checks);
      if (errors == 0 && checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // Ten clocks a phase, so the pin filter never drops an edge
   task acc(input r, input [14:0] a, input [7:0] d);
      reg [23:0] f;
      reg [7:0] q;
      integer i;
      {spi_cs_n, f} = {1'b0, r, a, r ? 8'h00 : d};
      for (i = 0; i < 24; i = i + 1) begin
         spi_sdi = f[23 - i];
         cyc(10);
         spi_sclk = 1;
         q = {q[6:0], spi_sdo_q};
         cyc(10);
         spi_sclk = 0;
      end
      cyc(10);
      spi_cs_n = 1;
      cyc(10);
      if (r)
         chk(q, d);
   endtask
   task pulse(input [7:0] n);
      fire = 1;
      cyc(12);
      fire = 0;
      cyc(40);
      chk(evn, n);
   endtask
   initial begin
      clk = 0;
      forever #4 clk = ~clk;
   end
   initial begin
      {errors, checks} = 64'd0;
      {rst_n, spi_sclk, spi_sdi, fire, sample_valid_in, output_timestamp_enable} = 6'h00;
      {decimation_bypass, spi_cs_n, sample_in, edge_position_in} = {2'b01, 36'h0003c5a96};
      cyc(2);
      {rst_n, sample_valid_in, sample_in} = 14'h30aa;
      cyc(6);
      acc(1, 15'h29, 8'h00);
      acc(1, 15'h2a, 8'h00);
      acc(0, 15'h29, 8'h20);
      pulse(8'h00);
      acc(0, 15'h29, 8'h60);
      pulse(8'h01);
      acc(0, 15'h29, 8'hff);
      acc(1, 15'h29, 8'h7f);
      chk({window_delay_fine_scale_q, capture_delay_select_q}, 24'h1f);
      acc(0, 15'h2a, 8'hff);
      chk({device_clock_dc_pecl_mode_q, sysref_dc_pecl_mode_q}, 24'h3);
      acc(1, 15'h2a, 8'h0f);
      {output_timestamp_enable, decimation_bypass} = 2'b11;
      cyc(50);
      chk(sample_q, 24'h0ab);
      chk(sample_valid_q, 24'h1);
      chk(evn, 24'h2);
      decimation_bypass = 0;
      cyc(3);
      chk(sample_q, 24'h0aa);
      acc(1, 15'h2c, 8'h96);
      acc(1, 15'h2d, 8'h5a);
      acc(1, 15'h2e, 8'h3c);
      acc(1, 15'h11, 8'h00);
      test_done;
   end
endmodule
